// >>> hdl/xlb_pkg.sv
/*
  Constants, opcode patterns and types for the logic and branch decoder.
  Assumes nothing beyond a SystemVerilog compiler; shared by the decoder, checker and bench.
*/
package xlb_pkg;

  // Opcode patterns with their match masks
  localparam logic [7:0] XLB_MASK_W = 8'hFE;
  localparam logic [7:0] XLB_MASK_VW = 8'hFC;
  localparam logic [7:0] XLB_MASK_CC = 8'hF0;
  localparam logic [7:0] XLB_OPC_GRP_F6 = 8'hF6;
  localparam logic [7:0] XLB_OPC_SHIFT = 8'hD0;
  localparam logic [7:0] XLB_OPC_AND_RM = 8'h20;
  localparam logic [7:0] XLB_OPC_TEST_ACC = 8'hA8;
  localparam logic [7:0] XLB_OPC_AND_ACC = 8'h24;
  localparam logic [7:0] XLB_OPC_XOR_ACC = 8'h34;
  localparam logic [7:0] XLB_OPC_OR_ACC = 8'h0C;
  localparam logic [7:0] XLB_OPC_MOVE = 8'hA4;
  localparam logic [7:0] XLB_OPC_CMP = 8'hA6;
  localparam logic [7:0] XLB_OPC_SCAN = 8'hAE;
  localparam logic [7:0] XLB_OPC_LOAD = 8'hAC;
  localparam logic [7:0] XLB_OPC_STORE = 8'hAA;
  localparam logic [7:0] XLB_OPC_RPT_PFX = 8'hF2;
  localparam logic [7:0] XLB_OPC_JMP_NEAR = 8'hE9;
  localparam logic [7:0] XLB_OPC_JMP_SHORT = 8'hEB;
  localparam logic [7:0] XLB_OPC_JMP_FAR = 8'hEA;
  localparam logic [7:0] XLB_OPC_RET_NEAR = 8'hC3;
  localparam logic [7:0] XLB_OPC_RET_NEAR_IMM = 8'hC2;
  localparam logic [7:0] XLB_OPC_RET_FAR = 8'hCB;
  localparam logic [7:0] XLB_OPC_RET_FAR_IMM = 8'hCA;
  localparam logic [7:0] XLB_OPC_JCC = 8'h70;
  localparam logic [7:0] XLB_OPC_LOOP = 8'hE2;
  localparam logic [7:0] XLB_OPC_LOOPZ = 8'hE1;
  localparam logic [7:0] XLB_OPC_LOOPNZ = 8'hE0;
  localparam logic [7:0] XLB_OPC_BR_CNT_ZERO = 8'hE3;
  localparam logic [7:0] XLB_OPC_INT_TYPE = 8'hCD;
  localparam logic [7:0] XLB_OPC_INT3 = 8'hCC;
  localparam logic [7:0] XLB_OPC_INT_OVF = 8'hCE;
  localparam logic [7:0] XLB_OPC_INT_RETURN = 8'hCF;

  // Middle field of the addressing byte
  localparam logic [2:0] XLB_MID_TEST = 3'h0;
  localparam logic [2:0] XLB_MID_INVERT = 3'h2;
  localparam logic [2:0] XLB_MID_ROT_L = 3'h0;
  localparam logic [2:0] XLB_MID_ROT_R = 3'h1;
  localparam logic [2:0] XLB_MID_ROT_CL = 3'h2;
  localparam logic [2:0] XLB_MID_ROT_CR = 3'h3;
  localparam logic [2:0] XLB_MID_SHIFT_L = 3'h4;
  localparam logic [2:0] XLB_MID_SHIFT_RL = 3'h5;
  localparam logic [2:0] XLB_MID_SHIFT_RA = 3'h7;

  // Reset values and fixed counts
  localparam logic [15:0] XLB_WORD_RST = 16'h0000;
  localparam logic [7:0] XLB_BYTE_RST = 8'h00;
  localparam logic [7:0] XLB_SHIFT_ONE = 8'h01;
  localparam logic [2:0] XLB_LEN_RST = 3'h0;

  typedef enum {
    XLB_ST_OPC, XLB_ST_MODRM, XLB_ST_DATA, XLB_ST_FIN
  } xlb_state_e;

  typedef enum logic [5:0] {
    XLB_OP_ILLEGAL, XLB_OP_TEST_IMM_RM, XLB_OP_INVERT,
    XLB_OP_SHIFT_LEFT, XLB_OP_LOGICAL_RIGHT_SHIFT, XLB_OP_ARITHMETIC_RIGHT_SHIFT,
    XLB_OP_ROTATE_LEFT, XLB_OP_ROTATE_RIGHT,
    XLB_OP_ROTATE_LEFT_THROUGH_CARRY, XLB_OP_ROTATE_RIGHT_THROUGH_CARRY,
    XLB_OP_AND_RM, XLB_OP_TEST_ACC, XLB_OP_AND_ACC, XLB_OP_XOR_ACC, XLB_OP_OR_ACC,
    XLB_OP_BLOCK_MOVE, XLB_OP_BLOCK_COMPARE, XLB_OP_ACCUMULATOR_SCAN,
    XLB_OP_STRING_LOAD, XLB_OP_STRING_STORE,
    XLB_OP_JMP_NEAR, XLB_OP_JMP_SHORT, XLB_OP_JMP_FAR,
    XLB_OP_RET_NEAR, XLB_OP_RET_NEAR_IMM, XLB_OP_RET_FAR, XLB_OP_RET_FAR_IMM,
    XLB_OP_JCC, XLB_OP_LOOP, XLB_OP_LOOPZ, XLB_OP_LOOPNZ,
    XLB_OP_BRANCH_IF_COUNT_ZERO,
    XLB_OP_INT_TYPE, XLB_OP_INT3, XLB_OP_INT_OVF, XLB_OP_INTERRUPT_RETURN
  } xlb_op_e;

endpackage

// >>> hdl/xlb_cond_eval.sv
/*
  Condition evaluator for the sixteen conditional branch opcodes.
  Assumes flags are stable, same-clock levels from the flag register.
*/
`timescale 1ns/1ns
module xlb_cond_eval (
  input wire logic [3:0] cond_in, // Low nibble of the branch opcode
  input wire logic zf_in,         // Zero flag
  input wire logic sf_in,         // Sign flag
  input wire logic of_in,         // Overflow flag
  input wire logic cf_in,         // Carry flag
  input wire logic pf_in,         // Parity flag, high on even parity
  output logic taken_out          // Condition holds
);
  logic base;

  always_comb begin
    case (cond_in[3:1])
      3'h0: base = of_in;
      3'h1: base = cf_in;
      3'h2: base = zf_in;
      3'h3: base = cf_in | zf_in;
      3'h4: base = sf_in;
      3'h5: base = pf_in;
      3'h6: base = sf_in ^ of_in;
      3'h7: base = (sf_in ^ of_in) | zf_in;
      default: base = 1'b0;
    endcase
  end

  // Odd opcodes take the inverse condition
  assign taken_out = base ^ cond_in[0];
endmodule

// >>> hdl/xlb_decoder.sv
/*
  Logic, string and control-transfer decoder of a 16-bit core.
  Assumes a same-clock instruction byte stream with valid/ready, and flag,
  count and next-address levels that are valid when the last byte is taken.
*/
`timescale 1ns/1ns
module xlb_decoder (
  input wire logic clk_in,                  // 25 MHz core clock
  input wire logic rst_n_in,                // Async reset, active low
  input wire logic byte_valid_in,           // Instruction byte offered
  input wire logic [7:0] byte_in,           // Instruction byte
  output logic byte_ready_out,              // Byte is taken when valid
  input wire logic zf_in,                   // Zero flag
  input wire logic sf_in,                   // Sign flag
  input wire logic of_in,                   // Overflow flag
  input wire logic cf_in,                   // Carry flag
  input wire logic pf_in,                   // Parity flag
  input wire logic [15:0] count_in,         // Count register
  input wire logic [15:0] next_ip_in,       // Address after this instruction
  output logic done_out,                    // Decode result valid, one cycle
  output xlb_pkg::xlb_op_e op_out,          // Decoded operation
  output logic wide_out,                    // Word operand
  output logic dir_out,                     // Register is destination
  output logic [7:0] modrm_out,             // Addressing byte
  output logic [15:0] imm_out,              // Data, offset or type byte
  output logic [15:0] seg_out,              // Far segment
  output logic [2:0] len_out,               // Bytes after any prefix
  output logic [7:0] shift_count_out,       // Shift or rotate count
  output logic rpt_out,                     // Repeat prefix seen
  output logic rpt_go_out,                  // Repeated primitive runs now
  output logic taken_out,                   // Control passes to target
  output logic [15:0] target_out,           // Relative branch target
  output logic count_dec_out                // Count register to decrement
);
  import xlb_pkg::*;

  xlb_state_e state_r;
  xlb_op_e op_r;
  xlb_op_e op_d;
  xlb_op_e op_m;
  xlb_op_e op_cur;
  logic need_modrm_d;
  logic [2:0] trail_d;
  logic [2:0] trail_m;
  logic [2:0] left_r;
  logic [1:0] idx_r;
  logic [3:0] cond_r;
  logic [3:0] cond_cur;
  logic shift_v_r;
  logic rpt_z_r;
  logic rpt_pend_r;
  logic take;
  logic is_prefix;
  logic fin_take;
  logic cond_ok;
  logic branch_ok;
  logic [15:0] disp;

  assign take = byte_valid_in & byte_ready_out;
  assign byte_ready_out = (state_r != XLB_ST_FIN);
  assign done_out = (state_r == XLB_ST_FIN);
  assign is_prefix = ((byte_in & XLB_MASK_W) == XLB_OPC_RPT_PFX);

  // First-byte decode
  always_comb begin
    op_d = XLB_OP_ILLEGAL;
    need_modrm_d = 1'b0;
    trail_d = 3'h0;
    if ((byte_in & XLB_MASK_W) == XLB_OPC_GRP_F6) begin
      op_d = XLB_OP_TEST_IMM_RM;
      need_modrm_d = 1'b1;
    end else if ((byte_in & XLB_MASK_VW) == XLB_OPC_SHIFT) begin
      op_d = XLB_OP_SHIFT_LEFT;
      need_modrm_d = 1'b1;
    end else if ((byte_in & XLB_MASK_VW) == XLB_OPC_AND_RM) begin
      op_d = XLB_OP_AND_RM;
      need_modrm_d = 1'b1;
    end else if ((byte_in & XLB_MASK_CC) == XLB_OPC_JCC) begin
      op_d = XLB_OP_JCC;
      trail_d = 3'h1;
    end else begin
      case (byte_in & XLB_MASK_W)
        XLB_OPC_TEST_ACC: op_d = XLB_OP_TEST_ACC;
        XLB_OPC_AND_ACC: op_d = XLB_OP_AND_ACC;
        XLB_OPC_XOR_ACC: op_d = XLB_OP_XOR_ACC;
        XLB_OPC_OR_ACC: op_d = XLB_OP_OR_ACC;
        XLB_OPC_MOVE: op_d = XLB_OP_BLOCK_MOVE;
        XLB_OPC_CMP: op_d = XLB_OP_BLOCK_COMPARE;
        XLB_OPC_SCAN: op_d = XLB_OP_ACCUMULATOR_SCAN;
        XLB_OPC_LOAD: op_d = XLB_OP_STRING_LOAD;
        XLB_OPC_STORE: op_d = XLB_OP_STRING_STORE;
        default: op_d = XLB_OP_ILLEGAL;
      endcase
      case (op_d)
        XLB_OP_TEST_ACC, XLB_OP_AND_ACC, XLB_OP_XOR_ACC, XLB_OP_OR_ACC: begin
          trail_d = byte_in[0] ? 3'h2 : 3'h1;
        end
        default: trail_d = 3'h0;
      endcase
      case (byte_in)
        XLB_OPC_JMP_NEAR: begin
          op_d = XLB_OP_JMP_NEAR;
          trail_d = 3'h2;
        end
        XLB_OPC_JMP_SHORT: begin
          op_d = XLB_OP_JMP_SHORT;
          trail_d = 3'h1;
        end
        XLB_OPC_JMP_FAR: begin
          op_d = XLB_OP_JMP_FAR;
          trail_d = 3'h4;
        end
        XLB_OPC_RET_NEAR: op_d = XLB_OP_RET_NEAR;
        XLB_OPC_RET_NEAR_IMM: begin
          op_d = XLB_OP_RET_NEAR_IMM;
          trail_d = 3'h2;
        end
        XLB_OPC_RET_FAR: op_d = XLB_OP_RET_FAR;
        XLB_OPC_RET_FAR_IMM: begin
          op_d = XLB_OP_RET_FAR_IMM;
          trail_d = 3'h2;
        end
        XLB_OPC_LOOP: begin
          op_d = XLB_OP_LOOP;
          trail_d = 3'h1;
        end
        XLB_OPC_LOOPZ: begin
          op_d = XLB_OP_LOOPZ;
          trail_d = 3'h1;
        end
        XLB_OPC_LOOPNZ: begin
          op_d = XLB_OP_LOOPNZ;
          trail_d = 3'h1;
        end
        XLB_OPC_BR_CNT_ZERO: begin
          op_d = XLB_OP_BRANCH_IF_COUNT_ZERO;
          trail_d = 3'h1;
        end
        XLB_OPC_INT_TYPE: begin
          op_d = XLB_OP_INT_TYPE;
          trail_d = 3'h1;
        end
        XLB_OPC_INT3: op_d = XLB_OP_INT3;
        XLB_OPC_INT_OVF: op_d = XLB_OP_INT_OVF;
        XLB_OPC_INT_RETURN: op_d = XLB_OP_INTERRUPT_RETURN;
        default: ;
      endcase
    end
  end

  // Addressing-byte refinement of the grouped opcodes
  always_comb begin
    op_m = op_r;
    trail_m = 3'h0;
    if (op_r == XLB_OP_TEST_IMM_RM) begin
      case (byte_in[5:3])
        XLB_MID_TEST: trail_m = wide_out ? 3'h2 : 3'h1;
        XLB_MID_INVERT: op_m = XLB_OP_INVERT;
        default: op_m = XLB_OP_ILLEGAL; // Other arithmetic lives elsewhere
      endcase
    end else if (op_r == XLB_OP_SHIFT_LEFT) begin
      case (byte_in[5:3])
        XLB_MID_SHIFT_L: op_m = XLB_OP_SHIFT_LEFT;
        XLB_MID_SHIFT_RL: op_m = XLB_OP_LOGICAL_RIGHT_SHIFT;
        XLB_MID_SHIFT_RA: op_m = XLB_OP_ARITHMETIC_RIGHT_SHIFT;
        XLB_MID_ROT_L: op_m = XLB_OP_ROTATE_LEFT;
        XLB_MID_ROT_R: op_m = XLB_OP_ROTATE_RIGHT;
        XLB_MID_ROT_CL: op_m = XLB_OP_ROTATE_LEFT_THROUGH_CARRY;
        XLB_MID_ROT_CR: op_m = XLB_OP_ROTATE_RIGHT_THROUGH_CARRY;
        default: op_m = XLB_OP_ILLEGAL;
      endcase
    end
  end

  always_comb begin
    op_cur = op_r;
    cond_cur = cond_r;
    fin_take = 1'b0;
    case (state_r)
      XLB_ST_OPC: begin
        op_cur = op_d;
        cond_cur = byte_in[3:0];
        fin_take = take & ~is_prefix & ~need_modrm_d & (trail_d == 3'h0);
      end
      XLB_ST_MODRM: begin
        op_cur = op_m;
        fin_take = take & (trail_m == 3'h0);
      end
      XLB_ST_DATA: fin_take = take & (left_r == 3'h1);
      default: fin_take = 1'b0;
    endcase
  end

  xlb_cond_eval u_cond (
    .cond_in(cond_cur),
    .zf_in(zf_in),
    .sf_in(sf_in),
    .of_in(of_in),
    .cf_in(cf_in),
    .pf_in(pf_in),
    .taken_out(cond_ok)
  );

  // Near jump takes its low byte from the stream first
  assign disp = (op_cur == XLB_OP_JMP_NEAR) ? {byte_in, imm_out[7:0]}
                                             : {{8{byte_in[7]}}, byte_in};

  always_comb begin
    case (op_cur)
      XLB_OP_JCC: branch_ok = cond_ok;
      XLB_OP_LOOP: branch_ok = (count_in != 16'h0001);
      XLB_OP_LOOPZ: branch_ok = (count_in != 16'h0001) & zf_in;
      XLB_OP_LOOPNZ: branch_ok = (count_in != 16'h0001) & ~zf_in;
      XLB_OP_BRANCH_IF_COUNT_ZERO: branch_ok = (count_in == XLB_WORD_RST);
      XLB_OP_INT_OVF: branch_ok = of_in;
      XLB_OP_JMP_NEAR, XLB_OP_JMP_SHORT, XLB_OP_JMP_FAR, XLB_OP_RET_NEAR,
      XLB_OP_RET_NEAR_IMM, XLB_OP_RET_FAR, XLB_OP_RET_FAR_IMM, XLB_OP_INT_TYPE,
      XLB_OP_INT3, XLB_OP_INTERRUPT_RETURN: branch_ok = 1'b1;
      default: branch_ok = 1'b0;
    endcase
  end

  // Sequencer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= XLB_ST_OPC;
      left_r <= 3'h0;
      idx_r <= 2'h0;
    end else begin
      case (state_r)
        XLB_ST_OPC: begin
          idx_r <= 2'h0;
          left_r <= trail_d;
          if (fin_take) begin
            state_r <= XLB_ST_FIN;
          end else if (take && !is_prefix) begin
            state_r <= need_modrm_d ? XLB_ST_MODRM : XLB_ST_DATA;
          end
        end
        XLB_ST_MODRM: begin
          left_r <= trail_m;
          if (take) begin
            state_r <= fin_take ? XLB_ST_FIN : XLB_ST_DATA;
          end
        end
        XLB_ST_DATA: begin
          if (take) begin
            left_r <= left_r - 3'h1;
            idx_r <= idx_r + 2'h1;
            state_r <= fin_take ? XLB_ST_FIN : XLB_ST_DATA;
          end
        end
        XLB_ST_FIN: state_r <= XLB_ST_OPC;
        default: state_r <= XLB_ST_OPC;
      endcase
    end
  end

  // Opcode fields and operation
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op_r <= XLB_OP_ILLEGAL;
      wide_out <= 1'b0;
      dir_out <= 1'b0;
      shift_v_r <= 1'b0;
      cond_r <= 4'h0;
      modrm_out <= XLB_BYTE_RST;
      len_out <= XLB_LEN_RST;
    end else if (take && !(state_r == XLB_ST_OPC && is_prefix)) begin
      len_out <= (state_r == XLB_ST_OPC) ? 3'h1 : len_out + 3'h1;
      if (state_r == XLB_ST_OPC) begin
        op_r <= op_d;
        wide_out <= byte_in[0];
        dir_out <= byte_in[1];
        shift_v_r <= byte_in[1];
        cond_r <= byte_in[3:0];
        modrm_out <= XLB_BYTE_RST;
      end else if (state_r == XLB_ST_MODRM) begin
        op_r <= op_m;
        modrm_out <= byte_in;
      end
    end
  end

  // Trailing data, offset and segment bytes, low byte first
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      imm_out <= XLB_WORD_RST;
      seg_out <= XLB_WORD_RST;
    end else if (take && state_r == XLB_ST_OPC && !is_prefix) begin
      imm_out <= XLB_WORD_RST;
      seg_out <= XLB_WORD_RST;
    end else if (take && state_r == XLB_ST_DATA) begin
      case (idx_r)
        2'h0: imm_out[7:0] <= byte_in;
        2'h1: imm_out[15:8] <= byte_in;
        2'h2: seg_out[7:0] <= byte_in;
        2'h3: seg_out[15:8] <= byte_in;
        default: ;
      endcase
    end
  end

  // Branch resolution on the last byte
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      taken_out <= 1'b0;
      target_out <= XLB_WORD_RST;
      count_dec_out <= 1'b0;
      shift_count_out <= XLB_BYTE_RST;
      rpt_go_out <= 1'b0;
    end else if (fin_take) begin
      taken_out <= branch_ok;
      case (op_cur)
        XLB_OP_JMP_NEAR, XLB_OP_JMP_SHORT, XLB_OP_JCC, XLB_OP_LOOP, XLB_OP_LOOPZ,
        XLB_OP_LOOPNZ, XLB_OP_BRANCH_IF_COUNT_ZERO: target_out <= next_ip_in + disp;
        default: target_out <= XLB_WORD_RST;
      endcase
      count_dec_out <= (op_cur == XLB_OP_LOOP) | (op_cur == XLB_OP_LOOPZ) |
                       (op_cur == XLB_OP_LOOPNZ);
      shift_count_out <= shift_v_r ? count_in[7:0] : XLB_SHIFT_ONE;
      // Pending flag, since rpt_out itself moves on this same edge
      case (op_cur)
        XLB_OP_BLOCK_COMPARE, XLB_OP_ACCUMULATOR_SCAN: begin
          rpt_go_out <= rpt_pend_r & (count_in != XLB_WORD_RST) & (zf_in == rpt_z_r);
        end
        XLB_OP_BLOCK_MOVE, XLB_OP_STRING_LOAD, XLB_OP_STRING_STORE: begin
          rpt_go_out <= rpt_pend_r & (count_in != XLB_WORD_RST);
        end
        default: rpt_go_out <= 1'b0;
      endcase
    end
  end

  // Repeat prefix waits for its opcode, then stands with that result
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rpt_pend_r <= 1'b0;
      rpt_z_r <= 1'b0;
      rpt_out <= 1'b0;
    end else if (take && state_r == XLB_ST_OPC) begin
      rpt_pend_r <= is_prefix;
      if (is_prefix) begin
        rpt_z_r <= byte_in[0];
      end else begin
        rpt_out <= rpt_pend_r;
      end
    end
  end

  assign op_out = op_r;
endmodule

// >>> sim/xlb_chk.sv
/*
  Concurrent checks on the decoder's result ports.
  Assumes it is bound to xlb_decoder and sees only its ports.
*/
`timescale 1ns/1ns
module xlb_chk (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic byte_valid_in,
  input wire logic byte_ready_out,
  input wire logic of_in,
  input wire logic [15:0] count_in,
  input wire logic [15:0] next_ip_in,
  input wire logic done_out,
  input xlb_pkg::xlb_op_e op_out,
  input wire logic [15:0] imm_out,
  input wire logic [2:0] len_out,
  input wire logic taken_out,
  input wire logic [15:0] target_out,
  input wire logic count_dec_out
);
  import xlb_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [15:0] rel_w;
  assign rel_w = {{8{imm_out[7]}}, imm_out[7:0]};
  sequence s_take;
    byte_valid_in && byte_ready_out;
  endsequence
  sequence s_fin;
    s_take ##1 done_out;
  endsequence
  chk_done_pulse:
    assert property (s_fin |=> !done_out && byte_ready_out)
    else $error("done not a single pulse");
  chk_ready_low:
    assert property (done_out |-> !byte_ready_out)
    else $error("ready high in done cycle");
  chk_short_jump:
    assert property (done_out && op_out == XLB_OP_JMP_SHORT |->
      len_out == 3'h2 && taken_out && target_out == $past(next_ip_in) + rel_w)
    else $error("short jump wrong");
  chk_near_jump:
    assert property (done_out && op_out == XLB_OP_JMP_NEAR |->
      len_out == 3'h3 && target_out == $past(next_ip_in) + imm_out)
    else $error("near jump wrong");
  chk_ret_imm:
    assert property (done_out && op_out == XLB_OP_RET_NEAR_IMM |-> len_out == 3'h3)
    else $error("return length wrong");
  chk_cond_branch:
    assert property (done_out && op_out == XLB_OP_JCC |-> len_out == 3'h2
      && (!taken_out || target_out == $past(next_ip_in) + rel_w))
    else $error("conditional branch wrong");
  chk_loop_count:
    assert property (done_out && op_out == XLB_OP_LOOP |->
      count_dec_out && taken_out == ($past(count_in) != 16'h0001))
    else $error("loop wrong");
  chk_count_zero:
    assert property (done_out && op_out == XLB_OP_BRANCH_IF_COUNT_ZERO |->
      taken_out == ($past(count_in) == 16'h0000))
    else $error("count zero branch wrong");
  chk_ovf_int:
    assert property (done_out && op_out == XLB_OP_INT_OVF |-> taken_out == $past(of_in))
    else $error("overflow interrupt wrong");
endmodule

bind xlb_decoder xlb_chk u_chk (.clk_in, .rst_n_in, .byte_valid_in, .byte_ready_out,
  .of_in, .count_in, .next_ip_in, .done_out, .op_out, .imm_out, .len_out, .taken_out,
  .target_out, .count_dec_out);

// >>> sim/xlb_prog_mem.sv
/*
  Program memory model feeding instruction bytes from a queue.
  Assumes the bench pushes bytes into q and drives stall_in.
*/
`timescale 1ns/1ns
module xlb_prog_mem (
  input wire logic clk_in,      // Core clock
  input wire logic rst_n_in,    // Async reset, active low
  input wire logic stall_in,    // Hold back a new byte
  input wire logic ready_in,    // Decoder takes byte
  output logic valid_out = 1'b0, // Byte offered
  output logic [7:0] byte_out = 8'h00 // Offered byte
);
  logic [7:0] q[$];
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q.delete();
      valid_out <= 1'b0;
      byte_out <= 8'h00;
    end else if (!valid_out || ready_in) begin
      if (valid_out) q.delete(0);
      if (q.size() != 0 && !stall_in) begin
        valid_out <= 1'b1;
        byte_out <= q[0];
      end else begin
        // Released bus inverts the shown byte on each idle cycle
        valid_out <= 1'b0;
        byte_out <= ~byte_out;
      end
    end
  end
endmodule

// >>> sim/tb_top.sv
/*
  Self-checking bench for the logic and branch decoder.
  Assumes xlb_pkg, xlb_decoder, xlb_prog_mem and the bound checker.
*/
`timescale 1ns/1ns
module tb_top;
  import xlb_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic stall = 1'b0;
  logic zf_in = 1'b0, sf_in = 1'b0, of_in = 1'b0, cf_in = 1'b0, pf_in = 1'b0;
  logic [15:0] count_in = 16'h0000, next_ip_in = 16'h0000;
  logic byte_valid_in, byte_ready_out, done_out, wide_out, dir_out;
  logic rpt_out, rpt_go_out, taken_out, count_dec_out;
  logic [7:0] byte_in, modrm_out, shift_count_out;
  logic [15:0] imm_out, seg_out, target_out;
  logic [2:0] len_out;
  xlb_op_e op_out;
  int failures = 0, n_tests = 0, cyc = 0;
  logic [31:0] seed = 32'h34;
  xlb_op_e lop[4] = '{XLB_OP_LOOPNZ, XLB_OP_LOOPZ, XLB_OP_LOOP, XLB_OP_BRANCH_IF_COUNT_ZERO};
  xlb_op_e sop[8] = '{XLB_OP_ROTATE_LEFT, XLB_OP_ROTATE_RIGHT,
    XLB_OP_ROTATE_LEFT_THROUGH_CARRY, XLB_OP_ROTATE_RIGHT_THROUGH_CARRY, XLB_OP_SHIFT_LEFT,
    XLB_OP_LOGICAL_RIGHT_SHIFT, XLB_OP_ILLEGAL, XLB_OP_ARITHMETIC_RIGHT_SHIFT};
  xlb_op_e aop[4] = '{XLB_OP_TEST_ACC, XLB_OP_AND_ACC, XLB_OP_XOR_ACC, XLB_OP_OR_ACC};
  xlb_op_e top[5] = '{XLB_OP_BLOCK_MOVE, XLB_OP_BLOCK_COMPARE, XLB_OP_ACCUMULATOR_SCAN,
    XLB_OP_STRING_LOAD, XLB_OP_STRING_STORE};
  logic [7:0] abase[4] = '{8'hA8, 8'h24, 8'h34, 8'h0C};
  logic [7:0] sbase[5] = '{8'hA4, 8'hA6, 8'hAE, 8'hAC, 8'hAA};

  xlb_decoder dut (.clk_in, .rst_n_in, .byte_valid_in, .byte_in, .byte_ready_out, .zf_in,
    .sf_in, .of_in, .cf_in, .pf_in, .count_in, .next_ip_in, .done_out, .op_out, .wide_out,
    .dir_out, .modrm_out, .imm_out, .seg_out, .len_out, .shift_count_out, .rpt_out,
    .rpt_go_out, .taken_out, .target_out, .count_dec_out);
  xlb_prog_mem mem (.clk_in, .rst_n_in, .stall_in(stall), .ready_in(byte_ready_out),
    .valid_out(byte_valid_in), .byte_out(byte_in));

  initial begin
    forever #20 clk_in = ~clk_in;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic cond(input logic [3:0] n, input logic z, s, v, y, a);
    logic t;
    case (n[3:1])
      3'h0: t = v;
      3'h1: t = y;
      3'h2: t = z;
      3'h3: t = y | z;
      3'h4: t = s;
      3'h5: t = a;
      3'h6: t = s ^ v;
      default: t = (s ^ v) | z;
    endcase
    return t ^ n[0];
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Drives one instruction, then compares the results with the model; modrm, seg and shift only where the opcode uses them
  task automatic ins(input logic [7:0] b[$], input xlb_op_e eop, input logic mr);
    logic [31:0] r, r2;
    logic [15:0] c, ip, tg, im;
    logic [7:0] o;
    logic tk, z, v, rel, two;
    int pi, n, di, k;
    pi = (b[0][7:1] == 7'h79);
    o = b[pi];
    n = b.size() - pi;
    di = pi + 1 + mr;
    r = rnd();
    r2 = rnd();
    z = r[0];
    v = r[2];
    c = r[7] ? r[23:8] : {14'h0000, r[6:5]};
    ip = r2[15:0];
    tg = (n > 1) ? ip + {{8{b[pi+1][7]}}, b[pi+1]} : 16'h0000;
    if (o == 8'hE9) tg = ip + {b[2], b[1]};
    rel = o[7:4] == 4'h7 || o[7:2] == 6'h38 || o == 8'hEB || o == 8'hE9;
    tk = 1'b0;
    if (o[7:4] == 4'h7) tk = cond(o[3:0], z, r[1], v, r[3], r[4]);
    else if (o[7:2] == 6'h38) tk = o[1:0] == 2'h3 ? c == 16'h0000 :
      c != 16'h0001 && (o[1] || o[0] == z);
    else if (o == 8'hCE) tk = v;
    else if (o inside {8'hE9, 8'hEA, 8'hEB, 8'hC2, 8'hC3, 8'hCA, 8'hCB}) tk = 1'b1;
    else if (o inside {8'hCC, 8'hCD, 8'hCF}) tk = 1'b1;
    two = b.size() > di + 1;
    im = 16'h0000;
    if (b.size() > di) im[7:0] = b[di];
    if (two) im[15:8] = b[di+1];
    @(posedge clk_in);
    zf_in <= z;
    sf_in <= r[1];
    of_in <= v;
    cf_in <= r[3];
    pf_in <= r[4];
    count_in <= c;
    next_ip_in <= ip;
    foreach (b[i]) mem.q.push_back(b[i]);
    k = 0;
    do begin
      @(negedge clk_in);
      k++;
    end while (done_out !== 1'b1 && k < 40);
    if (done_out !== 1'b1) begin
      failures++;
      close_out();
    end
    chk("op", op_out, eop);
    chk("len", len_out, 16'(n));
    chk("wide", wide_out, o[0]);
    chk("dir", dir_out, o[1]);
    chk("taken", taken_out, tk);
    chk("target", target_out, rel ? tg : 16'h0000);
    if (mr) chk("modrm", modrm_out, b[1]);
    chk("imm", imm_out, im);
    if (o == 8'hEA) chk("seg", seg_out, {b[4], b[3]});
    if (o[7:2] == 6'h34) chk("shift", shift_count_out, o[1] ? c[7:0] : 8'h01);
    chk("cdec", count_dec_out, o[7:2] == 6'h38 && o != 8'hE3);
    chk("rpt", rpt_out, pi != 0);
    chk("rptgo", rpt_go_out, pi != 0 && c != 16'h0000 &&
      (o[3:1] inside {3'h3, 3'h7} ? z == b[0][0] : 1'b1));
  endtask

  // Gaps in the byte stream exercise a slow memory
  always @(posedge clk_in) begin
    stall <= (cyc % 5) == 3;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    logic [31:0] r;
    logic [7:0] o;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(negedge clk_in);
    chk("rst_op", op_out, XLB_OP_ILLEGAL);
    chk("rst_rdy", byte_ready_out, 1'b1);
    for (int i = 0; i < 64; i++) begin
      r = rnd();
      ins('{{4'h7, i[3:0]}, r[7:0]}, XLB_OP_JCC, 1'b0);
    end
    for (int i = 0; i < 32; i++) begin
      r = rnd();
      ins('{{6'h38, i[1:0]}, r[7:0]}, lop[i%4], 1'b0);
    end
    r = rnd();
    ins('{8'hE9, r[7:0], r[15:8]}, XLB_OP_JMP_NEAR, 1'b0);
    ins('{8'hEB, r[23:16]}, XLB_OP_JMP_SHORT, 1'b0);
    ins('{8'hEA, r[7:0], r[15:8], r[23:16], r[31:24]}, XLB_OP_JMP_FAR, 1'b0);
    ins('{8'hC3}, XLB_OP_RET_NEAR, 1'b0);
    ins('{8'hC2, r[7:0], r[15:8]}, XLB_OP_RET_NEAR_IMM, 1'b0);
    ins('{8'hCB}, XLB_OP_RET_FAR, 1'b0);
    ins('{8'hCA, r[23:16], r[31:24]}, XLB_OP_RET_FAR_IMM, 1'b0);
    ins('{8'hCD, r[7:0]}, XLB_OP_INT_TYPE, 1'b0);
    ins('{8'hCC}, XLB_OP_INT3, 1'b0);
    ins('{8'hCE}, XLB_OP_INT_OVF, 1'b0);
    ins('{8'hCE}, XLB_OP_INT_OVF, 1'b0);
    ins('{8'hCF}, XLB_OP_INTERRUPT_RETURN, 1'b0);
    ins('{8'hF6, 8'hC1, r[7:0]}, XLB_OP_TEST_IMM_RM, 1'b1);
    ins('{8'hF7, 8'hC2, r[7:0], r[15:8]}, XLB_OP_TEST_IMM_RM, 1'b1);
    ins('{8'hF7, 8'hD3}, XLB_OP_INVERT, 1'b1);
    for (int i = 0; i < 32; i++)
      ins('{{6'h34, i[1:0]}, {2'h3, i[4:2], 3'h5}}, sop[i/4], 1'b1);
    for (int i = 0; i < 4; i++)
      ins('{{6'h08, i[1:0]}, 8'hC8}, XLB_OP_AND_RM, 1'b1);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      o = {abase[i/2][7:1], i[0]};
      if (i[0]) ins('{o, r[7:0], r[15:8]}, aop[i/2], 1'b0);
      else ins('{o, r[7:0]}, aop[i/2], 1'b0);
    end
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      o = {sbase[i%5][7:1], r[9]};
      if (r[10]) ins('{{7'h79, r[8]}, o}, top[i%5], 1'b0);
      else ins('{o}, top[i%5], 1'b0);
    end
    // Reset in mid-instruction must drop the partial decode
    mem.q.push_back(8'hE9);
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b0;
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(negedge clk_in);
    chk("rst_op", op_out, XLB_OP_ILLEGAL);
    ins('{8'hEB, 8'h80}, XLB_OP_JMP_SHORT, 1'b0);
    close_out();
  end
endmodule
